// [rtl/tpg_pkg.sv]
// package for the test frame generator: register map, fields, timing
package tpg_pkg;
	// register indices (5-bit management address)
	localparam logic [4:0] TPG_REG_CONTROL = 5'h1D;
	localparam logic [4:0] TPG_REG_PATTERN = 5'h1E;
	localparam logic [4:0] TPG_REG_PAGE = 5'h1F;
	localparam logic [4:0] TPG_REG_STATUS = 5'h1C;
	localparam logic [4:0] TPG_PAGED_LO = 5'h10;
	localparam logic [15:0] TPG_PAGE_MAIN = 16'h0000;
	localparam logic [15:0] TPG_PAGE_EXT1 = 16'h0001;
	localparam logic [15:0] TPG_PAGE_EXT2 = 16'h0002;
	// control field positions
	localparam int TPG_BIT_ENABLE = 15;
	localparam int TPG_BIT_RUN = 14;
	// reset values
	localparam logic [15:0] TPG_CONTROL_RST = 16'h0040;
	localparam logic [15:0] TPG_PATTERN_RST = 16'h0000;
	// frame lengths in bytes, including fcs
	localparam logic [13:0] TPG_LEN_125 = 14'h007D;
	localparam logic [13:0] TPG_LEN_64 = 14'h0040;
	localparam logic [13:0] TPG_LEN_1518 = 14'h05EE;
	localparam logic [13:0] TPG_LEN_JUMBO = 14'h2710;
	// frame counts
	localparam logic [24:0] TPG_BURST_FRAMES = 25'h1C9C380;
	localparam logic [13:0] TPG_BLOCK_FRAMES = 14'h2710;
	// frame layout
	localparam logic [3:0] TPG_PREAMBLE_BYTES = 4'h7;
	localparam logic [7:0] TPG_PREAMBLE = 8'h55;
	localparam logic [7:0] TPG_SFD = 8'hD5;
	localparam logic [13:0] TPG_HDR_BYTES = 14'h000C;
	localparam logic [13:0] TPG_FCS_BYTES = 14'h0004;
	localparam logic [31:0] TPG_CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] TPG_CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] TPG_CRC_BAD = 32'h0000FFFF;
	localparam logic [15:0] TPG_LFSR_SEED = 16'hACE1;
	// gaps
	localparam int TPG_CLK_MHZ = 50;
	localparam int TPG_GAP_SHORT_NS = 96;
	localparam int TPG_GAP_LONG_NS = 8192;
	localparam logic [8:0] TPG_GAP_SHORT_CYC = 9'((TPG_GAP_SHORT_NS * TPG_CLK_MHZ + 999) / 1000);
	localparam logic [8:0] TPG_GAP_LONG_CYC = 9'((TPG_GAP_LONG_NS * TPG_CLK_MHZ + 999) / 1000);

	// control register layout
	typedef struct packed {
		logic enable;
		logic run;
		logic continuous;
		logic [1:0] length_sel;
		logic long_gap;
		logic [3:0] dst_nibble;
		logic [3:0] src_nibble;
		logic random_payload;
		logic bad_fcs;
	} tpg_ctrl_t;

	// media-side byte stream
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic sof;
		logic eof;
	} tpg_byte_t;
endpackage

// [rtl/tpg_crc.sv]
// byte-wide running crc-32 for the frame check sequence
`timescale 1ns/10ps
module tpg_crc (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic init_in,
	input wire logic step_in,
	input wire logic [7:0] data_in,
	// result
	output logic [31:0] crc_out
);
	logic [31:0] crc_r;
	logic [31:0] crc_nxt;

	always_comb
	begin
		crc_nxt = crc_r;
		for (int i = 0; i < 8; i++)
		begin
			if (crc_nxt[0] ^ data_in[i])
				crc_nxt = (crc_nxt >> 1) ^ tpg_pkg::TPG_CRC_POLY;
			else
				crc_nxt = crc_nxt >> 1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			crc_r <= tpg_pkg::TPG_CRC_INIT;
		else if (init_in)
			crc_r <= tpg_pkg::TPG_CRC_INIT;
		else if (step_in)
			crc_r <= crc_nxt;
	end

	assign crc_out = crc_r;
endmodule

// [rtl/tpg_top.sv]
// test frame generator with its management registers and page select
// How it works
// - frames go out only while enable and run are both set; clearing run stops.
// - duration 0 sends thirty million frames then stops; 1 runs in blocks.
// - continuous turned off mid-run finishes the current ten-thousand-frame block.
// - length field picks 125, 64, 1518 or 10000 byte frames; default 125.
// - gap bit picks 8192 ns or 96 ns idle between frames.
// - destination is all ones with low nibble from its field, default 0001.
// - source is all ones with low nibble from its field, default 0000.
// - payload type picks random payload or the fixed pattern; resets to 0.
// - fcs bit picks a corrupted or a correct check sequence on every frame.
// - pattern register holds 16 bits, reset zero, repeated through fixed payload.
// - control bits 12..0 changed while running apply only after run or enable toggles.
// - pattern changes while running apply only after run or enable toggles.
// - writing 0x0002 to register 31 maps registers 16..30 onto page 2.
// - registers 0..15 always reach the standard space, whatever the page.
// - writing 0x0001 to register 31 returns 16..30 to the main space; 0x0000 maps them nowhere.
`timescale 1ns/10ps
module tpg_top (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// management port
	input wire logic [4:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// page state and forwarded access to other register sets
	output logic [15:0] page_out,
	output logic ext_page_hit_out,
	// media-side byte stream
	output tpg_pkg::tpg_byte_t tx_out,
	output logic busy_out
);
	typedef enum logic [2:0] {TPG_IDLE, TPG_PRE, TPG_HDR, TPG_PAY, TPG_FCS, TPG_GAP} tpg_state_t;

	logic [15:0] control_r;
	logic [15:0] pattern_r;
	logic [15:0] page_r;
	logic [15:0] reg_rdata_r;
	logic ext_hit_r;
	tpg_pkg::tpg_ctrl_t live_r;
	logic [15:0] live_pat_r;
	logic run_d_r;
	tpg_state_t state_r;
	logic [13:0] byte_cnt_r;
	logic [8:0] gap_cnt_r;
	logic [24:0] frame_cnt_r;
	logic [13:0] block_cnt_r;
	logic [15:0] lfsr_r;
	logic [1:0] fcs_idx_r;
	logic done_r;
	tpg_pkg::tpg_byte_t tx_r;
	logic crc_init;
	logic crc_step;
	logic [31:0] crc_val;
	logic [31:0] fcs_word;
	logic [7:0] hdr_byte;
	logic [7:0] pay_byte;
	logic [13:0] pay_len;
	logic [13:0] frame_len;
	logic wr_hit_main;
	logic rd_main;
	logic go;
	logic start;
	logic frame_end;
	logic stop_now;
	tpg_pkg::tpg_ctrl_t ctrl;

	assign ctrl = control_r;
	// only the page selector decides whether 16..30 reach this block
	assign rd_main = (reg_addr_in < tpg_pkg::TPG_PAGED_LO) || (page_r == tpg_pkg::TPG_PAGE_EXT1);
	assign wr_hit_main = reg_wr_in && rd_main;

	// page select
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			page_r <= tpg_pkg::TPG_PAGE_MAIN;
		else if (reg_wr_in && reg_addr_in == tpg_pkg::TPG_REG_PAGE)
			page_r <= reg_wdata_in;
	end

	// forwarded page-2 hit flag for the neighbouring register set
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ext_hit_r <= 1'b0;
		else
			ext_hit_r <= (reg_wr_in || reg_rd_in) && reg_addr_in >= tpg_pkg::TPG_PAGED_LO
				&& reg_addr_in != tpg_pkg::TPG_REG_PAGE
				&& page_r == tpg_pkg::TPG_PAGE_EXT2;
	end

	// software registers
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			control_r <= tpg_pkg::TPG_CONTROL_RST;
			pattern_r <= tpg_pkg::TPG_PATTERN_RST;
		end
		else
		begin
			// a pattern write must not swallow the self-stop of the same cycle
			if (wr_hit_main && reg_addr_in == tpg_pkg::TPG_REG_CONTROL)
				control_r <= reg_wdata_in;
			else if (done_r)
				control_r[tpg_pkg::TPG_BIT_RUN] <= 1'b0; // self-stop shows as run cleared
			if (wr_hit_main && reg_addr_in == tpg_pkg::TPG_REG_PATTERN)
				pattern_r <= reg_wdata_in;
		end
	end

	// read path, one cycle latency
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			reg_rdata_r <= 16'h0000;
		else if (reg_rd_in)
		begin
			if (reg_addr_in == tpg_pkg::TPG_REG_PAGE)
				reg_rdata_r <= page_r;
			else if (!rd_main)
				reg_rdata_r <= 16'h0000;
			else if (reg_addr_in == tpg_pkg::TPG_REG_CONTROL)
				reg_rdata_r <= control_r;
			else if (reg_addr_in == tpg_pkg::TPG_REG_PATTERN)
				reg_rdata_r <= pattern_r;
			else if (reg_addr_in == tpg_pkg::TPG_REG_STATUS)
				reg_rdata_r <= {(state_r != TPG_IDLE), frame_cnt_r[14:0]};
			else
				reg_rdata_r <= 16'h0000;
		end
		else
			reg_rdata_r <= 16'h0000;
	end

	assign go = ctrl.enable && ctrl.run;
	assign start = go && !run_d_r;

	// settings are snapshotted at each rising edge of enable and run both set
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			live_r <= tpg_pkg::TPG_CONTROL_RST;
			live_pat_r <= tpg_pkg::TPG_PATTERN_RST;
			run_d_r <= 1'b0;
		end
		else
		begin
			run_d_r <= go;
			if (start)
			begin
				live_r <= control_r;
				live_pat_r <= pattern_r;
			end
		end
	end

	always_comb
	begin
		unique case (live_r.length_sel)
			2'b00: frame_len = tpg_pkg::TPG_LEN_125;
			2'b01: frame_len = tpg_pkg::TPG_LEN_64;
			2'b10: frame_len = tpg_pkg::TPG_LEN_1518;
			2'b11: frame_len = tpg_pkg::TPG_LEN_JUMBO;
		endcase
	end
	assign pay_len = frame_len - tpg_pkg::TPG_HDR_BYTES - tpg_pkg::TPG_FCS_BYTES;

	// header: destination six bytes then source, all ones but the low nibble
	always_comb
	begin
		if (byte_cnt_r == 14'h0005)
			hdr_byte = {4'hF, live_r.dst_nibble};
		else if (byte_cnt_r == 14'h000B)
			hdr_byte = {4'hF, live_r.src_nibble};
		else
			hdr_byte = 8'hFF;
	end

	// type bit set gives random bytes, clear gives the pattern, high byte first
	assign pay_byte = live_r.random_payload ? lfsr_r[7:0]
		: (byte_cnt_r[0] ? live_pat_r[7:0] : live_pat_r[15:8]);

	// fcs bytes, least significant first; corrupted by flipping the low half
	assign fcs_word = ~crc_val ^ (live_r.bad_fcs ? tpg_pkg::TPG_CRC_BAD : 32'h00000000);

	assign frame_end = state_r == TPG_FCS && fcs_idx_r == 2'h3;
	// burst stops at its total; continuous switched off is the one live bit,
	// and it only ends the run at the next block mark
	assign stop_now = (!live_r.continuous
		&& frame_cnt_r + 25'h0000001 == tpg_pkg::TPG_BURST_FRAMES)
		|| (live_r.continuous && !ctrl.continuous
		&& block_cnt_r + 14'h0001 == tpg_pkg::TPG_BLOCK_FRAMES);

	assign crc_init = state_r == TPG_PRE;
	assign crc_step = state_r == TPG_HDR || state_r == TPG_PAY;

	tpg_crc u_crc (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.init_in(crc_init),
		.step_in(crc_step),
		.data_in(state_r == TPG_HDR ? hdr_byte : pay_byte),
		.crc_out(crc_val)
	);

	// frame sequencer
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_r <= TPG_IDLE;
			byte_cnt_r <= 14'h0000;
			gap_cnt_r <= 9'h000;
			fcs_idx_r <= 2'h0;
			done_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			if (!go || start)
			begin
				state_r <= go ? TPG_PRE : TPG_IDLE;
				byte_cnt_r <= 14'h0000;
				fcs_idx_r <= 2'h0;
			end
			else
			begin
				unique case (state_r)
					TPG_IDLE: ;
					TPG_PRE:
					begin
						byte_cnt_r <= byte_cnt_r + 14'h0001;
						if (byte_cnt_r == 14'(tpg_pkg::TPG_PREAMBLE_BYTES))
						begin
							state_r <= TPG_HDR;
							byte_cnt_r <= 14'h0000;
						end
					end
					TPG_HDR:
					begin
						byte_cnt_r <= byte_cnt_r + 14'h0001;
						if (byte_cnt_r == tpg_pkg::TPG_HDR_BYTES - 14'h0001)
						begin
							state_r <= TPG_PAY;
							byte_cnt_r <= 14'h0000;
						end
					end
					TPG_PAY:
					begin
						byte_cnt_r <= byte_cnt_r + 14'h0001;
						if (byte_cnt_r == pay_len - 14'h0001)
							state_r <= TPG_FCS;
					end
					TPG_FCS:
					begin
						fcs_idx_r <= fcs_idx_r + 2'h1;
						if (frame_end)
						begin
							state_r <= TPG_GAP;
							gap_cnt_r <= live_r.long_gap ? tpg_pkg::TPG_GAP_LONG_CYC
								: tpg_pkg::TPG_GAP_SHORT_CYC;
							if (stop_now)
							begin
								state_r <= TPG_IDLE;
								done_r <= 1'b1;
							end
						end
					end
					TPG_GAP:
					begin
						gap_cnt_r <= gap_cnt_r - 9'h001;
						if (gap_cnt_r == 9'h001)
						begin
							state_r <= TPG_PRE;
							byte_cnt_r <= 14'h0000;
						end
					end
				endcase
			end
		end
	end

	// frame counters and random payload source
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			frame_cnt_r <= 25'h0000000;
			block_cnt_r <= 14'h0000;
			lfsr_r <= tpg_pkg::TPG_LFSR_SEED;
		end
		else if (start)
		begin
			frame_cnt_r <= 25'h0000000;
			block_cnt_r <= 14'h0000;
			lfsr_r <= tpg_pkg::TPG_LFSR_SEED;
		end
		else
		begin
			if (frame_end)
			begin
				// wraps so a continuous run never saturates
				frame_cnt_r <= frame_cnt_r + 25'h0000001;
				block_cnt_r <= (block_cnt_r + 14'h0001 == tpg_pkg::TPG_BLOCK_FRAMES) ?
					14'h0000 : block_cnt_r + 14'h0001;
			end
			if (state_r == TPG_PAY)
				lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		end
	end

	// output byte register
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			tx_r <= '0;
		else
		begin
			tx_r <= '0;
			if (go && !start)
			begin
				unique case (state_r)
					TPG_PRE:
					begin
						tx_r.valid <= 1'b1;
						tx_r.sof <= byte_cnt_r == 14'h0000;
						tx_r.data <= (byte_cnt_r == 14'(tpg_pkg::TPG_PREAMBLE_BYTES)) ?
							tpg_pkg::TPG_SFD : tpg_pkg::TPG_PREAMBLE;
					end
					TPG_HDR:
					begin
						tx_r.valid <= 1'b1;
						tx_r.data <= hdr_byte;
					end
					TPG_PAY:
					begin
						tx_r.valid <= 1'b1;
						tx_r.data <= pay_byte;
					end
					TPG_FCS:
					begin
						tx_r.valid <= 1'b1;
						tx_r.eof <= frame_end;
						tx_r.data <= fcs_word[8 * fcs_idx_r +: 8];
					end
					default: ;
				endcase
			end
		end
	end

	assign reg_rdata_out = reg_rdata_r;
	assign page_out = page_r;
	assign ext_page_hit_out = ext_hit_r;
	assign tx_out = tx_r;
	assign busy_out = run_d_r;
endmodule

// [verification/tpg_top_asserts.sv]
// port checker for the test frame generator
`timescale 1ns/10ps
module tpg_top_asserts (
	// clock, reset, management port
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [4:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	// page and stream
	input wire logic [15:0] page_out,
	input wire logic ext_page_hit_out,
	input wire tpg_pkg::tpg_byte_t tx_out,
	input wire logic busy_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
		else $error("read data outside slot");
	a_page_write: assert property (reg_wr_in && reg_addr_in == 5'h1F
		|=> page_out == $past(reg_wdata_in)) else $error("page not written");
	a_ext_hit: assert property ((reg_wr_in || reg_rd_in) && reg_addr_in >= 5'h10
		&& reg_addr_in <= 5'h1E && page_out == 16'h0002 |=> ext_page_hit_out)
		else $error("page two access missed");
	a_low_nohit: assert property ((reg_wr_in || reg_rd_in) && reg_addr_in < 5'h10
		|=> !ext_page_hit_out) else $error("low register paged");
	a_valid_busy: assert property (tx_out.valid |-> busy_out)
		else $error("byte sent while idle");
	a_preamble_end: assert property (tx_out.valid && tx_out.sof ##1 tx_out.valid [*7]
		|-> tx_out.data == 8'hD5) else $error("delimiter wrong");
	a_dst_top: assert property (tx_out.valid && tx_out.sof ##1 tx_out.valid [*8]
		|-> tx_out.data == 8'hFF) else $error("destination top byte wrong");
	a_gap_min: assert property (tx_out.valid && tx_out.eof |=> !tx_out.valid [*5])
		else $error("gap too short");
endmodule
bind tpg_top tpg_top_asserts u_asserts (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .page_out(page_out),
	.ext_page_hit_out(ext_page_hit_out), .tx_out(tx_out), .busy_out(busy_out));

// [verification/tpg_link_rx.sv]
// link partner model: captures the generated frames
`timescale 1ns/10ps
module tpg_link_rx (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// media-side stream
	input wire tpg_pkg::tpg_byte_t tx_in
);
	// sized for a jumbo frame plus preamble
	logic [7:0] buf_r [0:10015];
	int idx_r;
	int len_r;
	int frames_r;
	int idle_r;
	int gap_r;
	// listen only, never throttles: test traffic stays off live links
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			idx_r <= 0;
			frames_r <= 0;
			idle_r <= 0;
		end
		else if (tx_in.valid)
		begin
			buf_r[tx_in.sof ? 0 : idx_r] <= tx_in.data;
			idx_r <= tx_in.sof ? 1 : idx_r + 1;
			idle_r <= 0;
			if (tx_in.sof)
				gap_r <= idle_r;
			if (tx_in.eof)
			begin
				len_r <= tx_in.sof ? 1 : idx_r + 1;
				frames_r <= frames_r + 1;
			end
		end
		else
			idle_r <= idle_r + 1;
	end
endmodule

// [verification/test_packet_generator_tb_top.sv]
// self-checking bench for the test frame generator
`timescale 1ns/10ps
module test_packet_generator_tb_top;
	logic ref_clk_in;
	logic rst_n_in;
	logic [4:0] reg_addr_in;
	logic [15:0] reg_wdata_in;
	logic reg_wr_in;
	logic reg_rd_in;
	logic [15:0] reg_rdata_out;
	logic [15:0] page_out;
	logic ext_page_hit_out;
	tpg_pkg::tpg_byte_t tx_out;
	logic busy_out;
	int num_errors = 0;
	int checks_done = 0;
	tpg_top DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .page_out(page_out),
		.ext_page_hit_out(ext_page_hit_out), .tx_out(tx_out), .busy_out(busy_out));
	tpg_link_rx rx (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .tx_in(tx_out));
	initial
	begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			$display("Error %0t seen %h exp %h", $time, seen, exp);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		@(posedge ref_clk_in);
		chk({16'h0000, reg_rdata_out}, {16'h0000, exp});
	endtask
	task automatic wait_frames(input int k);
		int goal;
		goal = rx.frames_r + k;
		for (int i = 0; i < 25000 && rx.frames_r < goal; i++)
			@(posedge ref_clk_in);
		if (rx.frames_r < goal)
		begin
			num_errors++;
			wrap_up();
		end
	endtask
	function automatic logic [31:0] crc_of(input int last);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		for (int i = 8; i <= last; i++)
		begin
			c = c ^ {24'h000000, rx.buf_r[i]};
			for (int b = 0; b < 8; b++)
				c = (c >> 1) ^ (c[0] ? 32'hEDB88320 : 32'h00000000);
		end
		return ~c;
	endfunction
	task automatic t_regs();
		rd(5'h1F, 16'h0000);
		wr(5'h1F, 16'h0001);
		rd(5'h1D, 16'h0040);
		rd(5'h1E, 16'h0000);
		wr(5'h1F, 16'h0002);
		chk(page_out, 16'h0002);
		rd(5'h05, 16'h0000);
		chk(ext_page_hit_out, 1'b0);
		wr(5'h1D, 16'hC000);
		chk(ext_page_hit_out, 1'b1);
		rd(5'h1D, 16'h0000);
		wr(5'h1F, 16'h0000);
		rd(5'h1D, 16'h0000);
		wr(5'h1F, 16'h0001);
		rd(5'h1D, 16'h0040);
		chk(rx.frames_r, 0);
		$display("regs done");
	endtask
	task automatic t_frame(input logic [15:0] c, input logic [15:0] pat, input int len,
		input int gap);
		int p;
		wr(5'h1E, pat);
		wr(5'h1D, c | 16'hC000);
		wait_frames(2);
		chk(rx.len_r, len + 8);
		chk(rx.gap_r, gap);
		chk({rx.buf_r[10], rx.buf_r[11], rx.buf_r[12], rx.buf_r[13]}, {28'hFFFFFFF, c[9:6]});
		chk({rx.buf_r[16], rx.buf_r[17], rx.buf_r[18], rx.buf_r[19]}, {28'hFFFFFFF, c[5:2]});
		for (p = 0; !c[1] && p < len - 16; p++)
			chk(rx.buf_r[20 + p], p[0] ? pat[7:0] : pat[15:8]);
		p = len + 4;
		chk({rx.buf_r[p + 3], rx.buf_r[p + 2], rx.buf_r[p + 1], rx.buf_r[p]},
			crc_of(len + 3) ^ (c[0] ? 32'h0000FFFF : 32'h00000000));
		wr(5'h1D, c);
		$display("frame %0d done", len);
	endtask
	task automatic t_lengths();
		int lens [4] = '{125, 64, 1518, 10000};
		for (int k = 0; k < 5; k++)
			t_frame({3'h0, 2'(k), k == 4, 4'(k * 5), 4'(15 - k * 5), k[0], k[1]},
				16'hA55A ^ 16'(k), lens[k % 4], k == 4 ? 410 : 5);
	endtask
	task automatic t_hold();
		int n;
		wr(5'h1E, 16'h1111);
		wr(5'h1D, 16'hC840);
		wait_frames(1);
		wr(5'h1E, 16'h2222);
		wr(5'h1D, 16'hC040);
		wait_frames(2);
		chk(rx.len_r, 72);
		chk(rx.buf_r[20], 8'h11);
		wr(5'h1D, 16'h8040);
		// a byte launched beside the stop lands one edge later
		@(posedge ref_clk_in);
		n = rx.frames_r;
		rd(5'h1C, 16'h0003);
		repeat (300) @(posedge ref_clk_in);
		chk(rx.frames_r, n);
		chk(busy_out, 1'b0);
		wr(5'h1D, 16'h4040);
		repeat (300) @(posedge ref_clk_in);
		chk(rx.frames_r, n);
		wr(5'h1D, 16'hC040);
		wait_frames(1);
		chk(rx.len_r, 133);
		chk(rx.buf_r[21], 8'h22);
		// enable and run are dropped together, back to the control reset value
		wr(5'h1D, 16'h0040);
		$display("hold done");
	endtask
	task automatic t_cont();
		wr(5'h1D, 16'hE840);
		wait_frames(2);
		// continuous off mid-run: the block must still be finished
		wr(5'h1D, 16'hC840);
		wait_frames(2);
		chk(busy_out, 1'b1);
		chk(rx.len_r, 72);
		wr(5'h1D, 16'h0040);
		$display("cont done");
	endtask
	initial
	begin
		rst_n_in = 1'b0;
		reg_addr_in = 5'h00;
		reg_wdata_in = 16'h0000;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		@(posedge ref_clk_in);
		t_regs();
		t_lengths();
		t_hold();
		t_cont();
		wrap_up();
	end
endmodule
